// *** rtl/usb_lp_pkg.sv ***
package usb_lp_pkg;

    // Clock and suspend timing
    localparam int CLK_FREQ_HZ = 40_000_000;
    localparam int IDLE_TIME_US = 3000;
    localparam int IDLE_CYCLES = IDLE_TIME_US * (CLK_FREQ_HZ / 1_000_000);

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_INT_STAT = 8'h08;
    localparam logic [7:0] ADDR_INT_CLR = 8'h0C;
    localparam logic [7:0] ADDR_INT_EN = 8'h10;

    // Fields of transceiver_regulator_control
    localparam int CTRL_BUS_TRANSCEIVER_EN_BIT = 0;
    localparam int CTRL_STOPC_AVAIL_BIT = 1;
    localparam int CTRL_ONCHIP_3V3_REGULATOR_EN_BIT = 2;
    localparam int CTRL_RES_FLAG_BIT = 4;
    localparam int CTRL_RES_EN_BIT = 5;
    localparam int CTRL_PULLUP_BIT = 6;
    localparam int CTRL_MOD_RESET_BIT = 7;

    // Fields of the status register
    localparam int STAT_SUSPEND_BIT = 0;
    localparam int STAT_K_BIT = 1;
    localparam int STAT_MODE_LSB = 2;
    localparam int STAT_FUNC_BIT = 5;

    // Event bits, shared by status, clear and enable
    localparam int EVT_WIDTH = 2;
    localparam int EVT_SUSPEND_BIT = 0;
    localparam int EVT_RESUME_BIT = 1;

    // Reset values
    localparam logic [EVT_WIDTH-1:0] EVT_RESET = 2'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Chip power mode, Gray coded along run, wait, stops
    typedef enum logic [2:0] {
        PM_RUN = 3'h0,
        PM_WAIT = 3'h1,
        PM_STOP_A = 3'h3,
        PM_STOP_B = 3'h2,
        PM_STOP_C = 3'h6
    } power_mode_t;

endpackage : usb_lp_pkg

// *** rtl/usb_line_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module usb_line_monitor #(
    parameter int IDLE_CYCLES = usb_lp_pkg::IDLE_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Bus pins, asynchronous
    input wire logic i_dp_pin,
    input wire logic i_dm_pin,
    // Controller functional
    input wire logic i_active,
    // Line state
    output logic o_k_state,
    output logic o_suspended
);
    localparam int CW = $clog2(IDLE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(IDLE_CYCLES - 1);

    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [CW-1:0] cnt_q, cnt_d;
    logic susp_q, susp_d;
    logic idle_j;

    // Bit 1 is D+, bit 0 is D-; full-speed idle is J
    assign idle_j = (sync_q == 2'b10);
    assign o_k_state = (sync_q == 2'b01);
    assign o_suspended = susp_q;

    always_comb begin
        cnt_d = cnt_q;
        susp_d = susp_q;
        if (!i_active) begin
            // Flag held while halted so a stop mode keeps suspend
            cnt_d = '0;
        end else if (!idle_j) begin
            cnt_d = '0;
            susp_d = 1'b0;
        end else if (cnt_q == LAST) begin
            susp_d = 1'b1; // see RULE4
        end else begin
            cnt_d = cnt_q + CW'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            meta_q <= 2'b00;
            sync_q <= 2'b00;
            cnt_q <= '0;
            susp_q <= 1'b0;
        end else begin
            meta_q <= {i_dp_pin, i_dm_pin};
            sync_q <= meta_q;
            cnt_q <= cnt_d;
            susp_q <= susp_d;
        end
    end

    chk_idle_flag : assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE4
        $rose(susp_q) |-> $past(cnt_q) == LAST && $past(idle_j) && $past(i_active))
        else $error("suspend flag set without full idle time");

    chk_idle_break : assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE4
        i_active && !idle_j |=> !susp_q && cnt_q == '0)
        else $error("suspend flag kept through bus activity");
endmodule : usb_line_monitor
`default_nettype wire

// *** rtl/usb_resume_wake.sv ***
`timescale 1ns/10ps
`default_nettype none
module usb_resume_wake (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Conditions
    input wire logic i_resume_enable,
    input wire logic i_in_stop_c,
    input wire logic i_suspended,
    input wire logic i_k_state,
    // Flag and wake
    output logic o_resume_flag,
    output logic o_async_wake
);
    logic flag_q, flag_d;

    always_comb begin
        flag_d = flag_q;
        if (!i_resume_enable) begin
            flag_d = 1'b0; // see RULE7
        end else if (i_in_stop_c && i_suspended && i_k_state) begin
            flag_d = 1'b1; // see RULE5 see RULE10
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign o_resume_flag = flag_q;
    // Wake is a level so the halted clock tree needs no edge to see it
    assign o_async_wake = flag_q; // see RULE6

    chk_flag_cause : assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE10
        $rose(flag_q) |-> $past(i_resume_enable) && $past(i_in_stop_c)
            && $past(i_suspended) && $past(i_k_state))
        else $error("resume flag set without all conditions");

    chk_flag_set : assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE5
        i_resume_enable && i_in_stop_c && i_suspended && i_k_state |=> flag_q && o_async_wake)
        else $error("resume K-state missed");

    chk_flag_clear : assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE7
        !i_resume_enable |=> !flag_q ##1 !o_async_wake || i_resume_enable)
        else $error("resume flag not cleared with enable");
endmodule : usb_resume_wake
`default_nettype wire

// *** rtl/usb_suspend_resume_control.sv ***
// What this block does
// RULE1 - Firmware turns off the regulator and transceiver before stop mode A, where nothing works.
// RULE2 - Firmware turns off the regulator and transceiver before stop mode B, where nothing works.
// RULE3 - The controller can optionally stay working in stop mode C to serve USB suspend.
// RULE4 - The suspend idle flag sets after the bus has stayed idle for 3 ms.
// RULE5 - With resume enable set, a K-state on the bus sets the low-power resume flag.
// RULE6 - The resume flag raises an asynchronous wake that restarts the processor and clocks.
// RULE7 - Firmware clears resume enable after waking, and that clears the resume flag.
// RULE8 - In wait mode the controller keeps working exactly as in run mode.
// RULE9 - Firmware sets resume enable only after suspend is flagged and before stop mode C.
// RULE10 - The resume flag sets only with enable set, stop mode C, suspend and a K-state together.
// RULE11 - The data pins float after reset until firmware enables the transceiver.
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module usb_suspend_resume_control #(
    parameter int IDLE_CYCLES = usb_lp_pkg::IDLE_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // AXI4-Lite write address
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    // AXI4-Lite write data
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read address
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    // AXI4-Lite read data
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Chip power mode
    input wire logic [2:0] i_power_mode,
    // Packet engine drive request
    input wire logic i_tx_oe,
    input wire logic i_tx_dp,
    input wire logic i_tx_dm,
    // Bus pins
    input wire logic i_dp_pin,
    input wire logic i_dm_pin,
    output logic o_dp_out,
    output logic o_dp_oe,
    output logic o_dm_out,
    output logic o_dm_oe,
    // Analog controls
    output logic o_bus_transceiver_en,
    output logic o_onchip_3v3_regulator_en,
    output logic o_pullup_en,
    // Wake and interrupt
    output logic o_usb_functional,
    output logic o_async_wake,
    output logic o_irq
);
    // Register decode, shared by the read and write paths
    function automatic logic addr_known(input logic [7:0] addr);
        addr_known = (addr == usb_lp_pkg::ADDR_CTRL) || (addr == usb_lp_pkg::ADDR_STATUS)
            || (addr == usb_lp_pkg::ADDR_INT_STAT) || (addr == usb_lp_pkg::ADDR_INT_CLR)
            || (addr == usb_lp_pkg::ADDR_INT_EN);
    endfunction : addr_known

    usb_lp_pkg::power_mode_t mode;
    logic in_stop_c;
    logic functional;
    logic k_state;
    logic suspended;
    logic resume_flag;

    // Control bits
    logic bus_transceiver_en_q, bus_transceiver_en_d;
    logic onchip_3v3_regulator_en_q, onchip_3v3_regulator_en_d;
    logic stopc_avail_q, stopc_avail_d;
    logic res_en_q, res_en_d;
    logic pullup_q, pullup_d;

    // Events and interrupt
    logic [usb_lp_pkg::EVT_WIDTH-1:0] int_stat_q, int_stat_d;
    logic [usb_lp_pkg::EVT_WIDTH-1:0] int_en_q, int_en_d;
    logic [usb_lp_pkg::EVT_WIDTH-1:0] evt_set;
    logic [usb_lp_pkg::EVT_WIDTH-1:0] evt_clr;
    logic susp_prev_q;
    logic flag_prev_q;
    logic irq_q, irq_d;

    // Bus slave state
    logic aw_have_q, aw_have_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic w_have_q, w_have_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic do_write;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    // Pin drivers
    logic dp_out_q, dp_out_d;
    logic dm_out_q, dm_out_d;
    logic oe_q, oe_d;

    assign mode = usb_lp_pkg::power_mode_t'(i_power_mode);
    assign in_stop_c = (mode == usb_lp_pkg::PM_STOP_C);

    // Stop A and B halt the controller, not the register interface; firmware has powered the analog parts down first
    always_comb begin
        case (mode)
            usb_lp_pkg::PM_RUN: functional = 1'b1;
            usb_lp_pkg::PM_WAIT: functional = 1'b1; // see RULE8
            usb_lp_pkg::PM_STOP_A: functional = 1'b0; // see RULE1
            usb_lp_pkg::PM_STOP_B: functional = 1'b0; // see RULE2
            usb_lp_pkg::PM_STOP_C: functional = stopc_avail_q; // see RULE3
            default: functional = 1'b0;
        endcase
    end

    usb_line_monitor #(
        .IDLE_CYCLES(IDLE_CYCLES)
    ) u_line_monitor (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_dp_pin(i_dp_pin),
        .i_dm_pin(i_dm_pin),
        .i_active(functional),
        .o_k_state(k_state),
        .o_suspended(suspended)
    );

    usb_resume_wake u_resume_wake (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_resume_enable(res_en_q),
        .i_in_stop_c(in_stop_c),
        .i_suspended(suspended),
        .i_k_state(k_state),
        .o_resume_flag(resume_flag),
        .o_async_wake(o_async_wake)
    );

    // Bus slave: address and data may arrive in either order
    assign o_awready = !aw_have_q && !bvalid_q;
    assign o_wready = !w_have_q && !bvalid_q;
    assign o_arready = !rvalid_q;
    assign wr_addr = aw_have_q ? aw_addr_q : i_awaddr;
    assign wr_data = w_have_q ? w_data_q : i_wdata;
    assign wr_strb = w_have_q ? w_strb_q : i_wstrb;
    assign do_write = (aw_have_q || (i_awvalid && o_awready))
        && (w_have_q || (i_wvalid && o_wready)) && !bvalid_q;

    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d = w_have_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (bvalid_q && i_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_write) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = addr_known(wr_addr) ? usb_lp_pkg::RESP_OKAY : usb_lp_pkg::RESP_SLVERR;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_have_d = 1'b1;
                aw_addr_d = i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_have_d = 1'b1;
                w_data_d = i_wdata;
                w_strb_d = i_wstrb;
            end
        end
    end

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && i_rready) begin
            rvalid_d = 1'b0;
        end
        if (i_arvalid && o_arready) begin
            rvalid_d = 1'b1;
            rdata_d = 32'h0000_0000;
            rresp_d = addr_known(i_araddr) ? usb_lp_pkg::RESP_OKAY : usb_lp_pkg::RESP_SLVERR;
            case (i_araddr)
                usb_lp_pkg::ADDR_CTRL: begin
                    rdata_d[usb_lp_pkg::CTRL_BUS_TRANSCEIVER_EN_BIT] = bus_transceiver_en_q;
                    rdata_d[usb_lp_pkg::CTRL_STOPC_AVAIL_BIT] = stopc_avail_q;
                    rdata_d[usb_lp_pkg::CTRL_ONCHIP_3V3_REGULATOR_EN_BIT] = onchip_3v3_regulator_en_q;
                    rdata_d[usb_lp_pkg::CTRL_RES_FLAG_BIT] = resume_flag;
                    rdata_d[usb_lp_pkg::CTRL_RES_EN_BIT] = res_en_q;
                    rdata_d[usb_lp_pkg::CTRL_PULLUP_BIT] = pullup_q;
                end
                usb_lp_pkg::ADDR_STATUS: begin
                    rdata_d[usb_lp_pkg::STAT_SUSPEND_BIT] = suspended;
                    rdata_d[usb_lp_pkg::STAT_K_BIT] = k_state;
                    rdata_d[usb_lp_pkg::STAT_MODE_LSB +: 3] = i_power_mode;
                    rdata_d[usb_lp_pkg::STAT_FUNC_BIT] = functional;
                end
                usb_lp_pkg::ADDR_INT_STAT: rdata_d[usb_lp_pkg::EVT_WIDTH-1:0] = int_stat_q;
                usb_lp_pkg::ADDR_INT_EN: rdata_d[usb_lp_pkg::EVT_WIDTH-1:0] = int_en_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Control register writes; only byte lane 0 carries fields
    always_comb begin
        bus_transceiver_en_d = bus_transceiver_en_q;
        onchip_3v3_regulator_en_d = onchip_3v3_regulator_en_q;
        stopc_avail_d = stopc_avail_q;
        res_en_d = res_en_q;
        pullup_d = pullup_q;
        int_en_d = int_en_q;
        evt_clr = '0;
        if (do_write && wr_strb[0]) begin
            case (wr_addr)
                usb_lp_pkg::ADDR_CTRL: begin
                    if (wr_data[usb_lp_pkg::CTRL_MOD_RESET_BIT]) begin
                        // Module reset drops the analog enables; firmware restarts them
                        bus_transceiver_en_d = 1'b0;
                        onchip_3v3_regulator_en_d = 1'b0;
                        stopc_avail_d = 1'b0;
                        res_en_d = 1'b0;
                        pullup_d = 1'b0;
                    end else begin
                        bus_transceiver_en_d = wr_data[usb_lp_pkg::CTRL_BUS_TRANSCEIVER_EN_BIT];
                        onchip_3v3_regulator_en_d = wr_data[usb_lp_pkg::CTRL_ONCHIP_3V3_REGULATOR_EN_BIT];
                        stopc_avail_d = wr_data[usb_lp_pkg::CTRL_STOPC_AVAIL_BIT];
                        res_en_d = wr_data[usb_lp_pkg::CTRL_RES_EN_BIT];
                        pullup_d = wr_data[usb_lp_pkg::CTRL_PULLUP_BIT];
                    end
                end
                usb_lp_pkg::ADDR_INT_CLR: evt_clr = wr_data[usb_lp_pkg::EVT_WIDTH-1:0];
                usb_lp_pkg::ADDR_INT_EN: int_en_d = wr_data[usb_lp_pkg::EVT_WIDTH-1:0];
                default: int_en_d = int_en_q;
            endcase
        end
    end

    // Sticky events; a set in the clearing cycle wins
    assign evt_set[usb_lp_pkg::EVT_SUSPEND_BIT] = suspended && !susp_prev_q;
    assign evt_set[usb_lp_pkg::EVT_RESUME_BIT] = resume_flag && !flag_prev_q;

    always_comb begin
        int_stat_d = (int_stat_q & ~evt_clr) | evt_set;
        irq_d = |(int_stat_d & int_en_d);
    end

    // Pins float until the transceiver is enabled and the controller works
    always_comb begin
        oe_d = bus_transceiver_en_q && functional && i_tx_oe; // see RULE11
        dp_out_d = oe_d && i_tx_dp;
        dm_out_d = oe_d && i_tx_dm;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= usb_lp_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= usb_lp_pkg::RESP_OKAY;
            bus_transceiver_en_q <= 1'b0;
            onchip_3v3_regulator_en_q <= 1'b0;
            stopc_avail_q <= 1'b0;
            res_en_q <= 1'b0;
            pullup_q <= 1'b0;
            int_stat_q <= usb_lp_pkg::EVT_RESET;
            int_en_q <= usb_lp_pkg::EVT_RESET;
            susp_prev_q <= 1'b0;
            flag_prev_q <= 1'b0;
            irq_q <= 1'b0;
            oe_q <= 1'b0;
            dp_out_q <= 1'b0;
            dm_out_q <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q <= w_have_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            bus_transceiver_en_q <= bus_transceiver_en_d;
            onchip_3v3_regulator_en_q <= onchip_3v3_regulator_en_d;
            stopc_avail_q <= stopc_avail_d;
            res_en_q <= res_en_d;
            pullup_q <= pullup_d;
            int_stat_q <= int_stat_d;
            int_en_q <= int_en_d;
            susp_prev_q <= suspended;
            flag_prev_q <= resume_flag;
            irq_q <= irq_d;
            oe_q <= oe_d;
            dp_out_q <= dp_out_d;
            dm_out_q <= dm_out_d;
        end
    end

    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
    assign o_dp_out = dp_out_q;
    assign o_dm_out = dm_out_q;
    assign o_dp_oe = oe_q;
    assign o_dm_oe = oe_q;
    assign o_bus_transceiver_en = bus_transceiver_en_q;
    assign o_onchip_3v3_regulator_en = onchip_3v3_regulator_en_q;
    assign o_pullup_en = pullup_q;
    assign o_usb_functional = functional;
    assign o_irq = irq_q;

    chk_pins_float : assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE11
        !bus_transceiver_en_q |=> !o_dp_oe && !o_dm_oe)
        else $error("data pins driven with transceiver off");

    chk_wait_works : assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE8
        mode == usb_lp_pkg::PM_WAIT |-> o_usb_functional)
        else $error("controller halted in wait mode");

    chk_stopc_avail : assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE3
        in_stop_c |-> o_usb_functional == stopc_avail_q)
        else $error("stop mode C availability ignored");

    chk_wake_irq : assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE6
        $rose(resume_flag) && int_en_q[usb_lp_pkg::EVT_RESUME_BIT] |=> o_irq && o_async_wake)
        else $error("resume did not raise wake and interrupt");
endmodule : usb_suspend_resume_control
`default_nettype wire

// *** test/usb_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
    // Line state asked of the host: 0 idle J, 1 resume K, 2 SE0
    input wire logic [1:0] i_line,
    // Device drive
    input wire logic i_dp_oe,
    input wire logic i_dp_out,
    input wire logic i_dm_oe,
    input wire logic i_dm_out,
    // Resolved wire levels
    output logic o_dp,
    output logic o_dm
);
    // Device drive wins; otherwise the host, idle J from the device pull-up
    assign o_dp = i_dp_oe ? i_dp_out : (i_line == 2'h0);
    assign o_dm = i_dm_oe ? i_dm_out : (i_line == 2'h1);
endmodule : usb_host_model
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int IDLE = 16;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd;
    logic [2:0] pm = 3'h0;
    logic [2:0] modes [4] = '{usb_lp_pkg::PM_RUN, usb_lp_pkg::PM_WAIT,
        usb_lp_pkg::PM_STOP_A, usb_lp_pkg::PM_STOP_B};
    logic tx_oe = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] line = 2'h0, bresp, rresp, rsp;
    logic dp_w, dm_w, awready, wready, bvalid, arready, rvalid;
    logic [31:0] rdata;
    logic dp_out, dp_oe, dm_out, dm_oe, bus_transceiver_en, onchip_3v3_regulator_en, pu_en, func, wake, irq;
    int err_total = 0;
    int comparisons = 0;
    int seed = 32'hA9E1;
    int ctrl_m = 0;

    always #12.5 i_clk = ~i_clk;

    usb_suspend_resume_control #(.IDLE_CYCLES(IDLE)) uut (
        .i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .i_power_mode(pm), .i_tx_oe(tx_oe), .i_tx_dp(1'b1), .i_tx_dm(1'b0),
        .i_dp_pin(dp_w), .i_dm_pin(dm_w), .o_dp_out(dp_out), .o_dp_oe(dp_oe),
        .o_dm_out(dm_out), .o_dm_oe(dm_oe), .o_bus_transceiver_en(bus_transceiver_en), .o_onchip_3v3_regulator_en(onchip_3v3_regulator_en),
        .o_pullup_en(pu_en), .o_usb_functional(func), .o_async_wake(wake), .o_irq(irq));

    usb_host_model host (.i_line(line), .i_dp_oe(dp_oe), .i_dp_out(dp_out),
        .i_dm_oe(dm_oe), .i_dm_out(dm_out), .o_dp(dp_w), .o_dm(dm_w));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        forever begin
            @(posedge i_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        forever begin
            @(posedge i_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rd = rdata;
                rsp = rresp;
                rready <= 1'b0;
                break;
            end
        end
        chk(nm, e, rd);
        chk("rresp", {30'h0, (a > 8'h10) ? usb_lp_pkg::RESP_SLVERR : usb_lp_pkg::RESP_OKAY},
            {30'h0, rsp});
    endtask : rchk

    function automatic logic [31:0] st(input logic [2:0] m, input logic f, input logic s);
        return {26'h0, f, m, 1'b0, s};
    endfunction : st

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (6000) @(posedge i_clk);
        err_total++;
        $display("[FAIL] run_end expected done seen timeout");
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        chk("dp_oe", 0, dp_oe);
        chk("dm_oe", 0, dm_oe);
        chk("wake", 0, wake);
        rchk("ctrl", usb_lp_pkg::ADDR_CTRL, 0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            ctrl_m = $random(seed) & 32'h45;
            wr(usb_lp_pkg::ADDR_CTRL, ctrl_m, rsp);
            rchk("ctrl", usb_lp_pkg::ADDR_CTRL, ctrl_m);
            chk("bus_transceiver_en", ctrl_m[0], bus_transceiver_en);
            chk("onchip_3v3_regulator_en", ctrl_m[2], onchip_3v3_regulator_en);
            chk("pullup_en", ctrl_m[6], pu_en);
        end
        wr(usb_lp_pkg::ADDR_CTRL, 32'hFF, rsp);
        rchk("ctrl_modreset", usb_lp_pkg::ADDR_CTRL, 0);
        wr(8'h40, $random(seed), rsp);
        chk("unmapped_wr", usb_lp_pkg::RESP_SLVERR, rsp);
        rchk("unmapped_rd", 8'h40, 0);
        wstrb <= 4'h0;
        wr(usb_lp_pkg::ADDR_CTRL, 32'h45, rsp);
        wstrb <= 4'hF;
        chk("strb_resp", usb_lp_pkg::RESP_OKAY, rsp);
        rchk("ctrl_no_strb", usb_lp_pkg::ADDR_CTRL, 0);
        wr(usb_lp_pkg::ADDR_INT_EN, 32'h3, rsp);
        wr(usb_lp_pkg::ADDR_CTRL, 32'h47, rsp);
        $display("test registers done");
        // Same suspend behaviour in run and in wait
        for (int i = 0; i < 2; i++) begin
            pm <= modes[i];
            line <= 2'h1;
            repeat (4) @(posedge i_clk);
            wr(usb_lp_pkg::ADDR_INT_CLR, 32'h3, rsp);
            line <= 2'h0;
            repeat (4) @(posedge i_clk);
            rchk("status_early", usb_lp_pkg::ADDR_STATUS, st(modes[i], 1, 0));
            chk("irq", 0, irq);
            repeat (IDLE + 4) @(posedge i_clk);
            rchk("status", usb_lp_pkg::ADDR_STATUS, st(modes[i], 1, 1));
            rchk("int_stat", usb_lp_pkg::ADDR_INT_STAT, 1);
            chk("irq", 1, irq);
            tx_oe <= 1'b1;
            repeat (3) @(posedge i_clk);
            chk("dp_oe", 1, dp_oe);
            chk("dp_wire", 1, dp_w);
            chk("dm_oe", 1, dm_oe);
            chk("dm_wire", 0, dm_w);
            tx_oe <= 1'b0;
        end
        $display("test suspend done");
        for (int i = 2; i < 4; i++) begin
            wr(usb_lp_pkg::ADDR_CTRL, 32'h0, rsp);
            pm <= modes[i];
            tx_oe <= 1'b1;
            repeat (3) @(posedge i_clk);
            chk("func", 0, func);
            chk("dp_oe", 0, dp_oe);
            rchk("status_stop", usb_lp_pkg::ADDR_STATUS, st(modes[i], 0, 1));
            tx_oe <= 1'b0;
        end
        pm <= 3'h7;
        repeat (2) @(posedge i_clk);
        chk("func_bad_mode", 0, func);
        wr(usb_lp_pkg::ADDR_CTRL, 32'h45, rsp);
        pm <= usb_lp_pkg::PM_STOP_C;
        repeat (2) @(posedge i_clk);
        chk("func_c_off", 0, func);
        wr(usb_lp_pkg::ADDR_CTRL, 32'h47, rsp);
        @(posedge i_clk);
        chk("func_c_on", 1, func);
        $display("test stop modes done");
        pm <= usb_lp_pkg::PM_RUN;
        wr(usb_lp_pkg::ADDR_CTRL, 32'h67, rsp);
        chk("wr_resp", usb_lp_pkg::RESP_OKAY, rsp);
        line <= 2'h1;
        repeat (6) @(posedge i_clk);
        chk("wake_run", 0, wake);
        line <= 2'h0;
        repeat (IDLE + 8) @(posedge i_clk);
        pm <= usb_lp_pkg::PM_STOP_C;
        repeat (2) @(posedge i_clk);
        line <= 2'h1;
        repeat (5) @(posedge i_clk);
        chk("wake", 1, wake);
        rchk("ctrl_flag", usb_lp_pkg::ADDR_CTRL, 32'h77);
        rchk("int_stat", usb_lp_pkg::ADDR_INT_STAT, 3);
        chk("irq", 1, irq);
        pm <= usb_lp_pkg::PM_RUN;
        wr(usb_lp_pkg::ADDR_CTRL, 32'h47, rsp);
        repeat (2) @(posedge i_clk);
        chk("wake_clr", 0, wake);
        rchk("ctrl_clr", usb_lp_pkg::ADDR_CTRL, 32'h47);
        wr(usb_lp_pkg::ADDR_INT_CLR, 32'h1, rsp);
        wr(usb_lp_pkg::ADDR_INT_EN, 32'h1, rsp);
        repeat (2) @(posedge i_clk);
        chk("irq_masked", 0, irq);
        rchk("int_stat", usb_lp_pkg::ADDR_INT_STAT, 2);
        wr(usb_lp_pkg::ADDR_INT_CLR, 32'h3, rsp);
        rchk("int_stat_clr", usb_lp_pkg::ADDR_INT_STAT, 0);
        line <= 2'h0;
        $display("test resume done");
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        chk("irq_rst", 0, irq);
        rchk("ctrl_rst", usb_lp_pkg::ADDR_CTRL, 0);
        rchk("int_en_rst", usb_lp_pkg::ADDR_INT_EN, 0);
        $display("test reset again done");
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
